// >>> verilog/irq_flag_map.vh
// register map, field positions and reset values of the peripheral flag bank
// assumes a 32-bit classic wishbone slave with one aligned word per register
`ifndef IRQ_FLAG_MAP_VH
`define IRQ_FLAG_MAP_VH

// ----------------------------------------------------------------------
// byte offsets
// ----------------------------------------------------------------------
`define OFS_FLAGS1    8'h00
`define OFS_FLAGS2    8'h04
`define OFS_FLAGS3    8'h08
`define OFS_FLAGS4    8'h0c
`define OFS_ENABLE1   8'h10
`define OFS_ENABLE2   8'h14
`define OFS_ENABLE3   8'h18
`define OFS_ENABLE4   8'h1c
`define OFS_CORE_CTRL 8'h20
`define OFS_TMR0_OPT  8'h24

// ----------------------------------------------------------------------
// implemented bits and software-writable bits of each flag register
// ----------------------------------------------------------------------
`define IMPL_MASK1 8'hff
`define IMPL_MASK2 8'hf9
`define IMPL_MASK3 8'h3a
`define IMPL_MASK4 8'h03
`define SWWR_MASK1 8'hcf
`define SWWR_MASK2 8'hf9
`define SWWR_MASK3 8'h3a
`define SWWR_MASK4 8'h03

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_TIMER1_GATE    7
`define BIT_ADC_DONE       6
`define BIT_UART_RX        5
`define BIT_UART_TX        4
`define BIT_SYNC_PORT1     3
`define BIT_CAPTURE1       2
`define BIT_TIMER2_MATCH   1
`define BIT_TIMER1_OVF     0
`define BIT_OSC_FAIL       7
`define BIT_COMPARATOR2    6
`define BIT_COMPARATOR1    5
`define BIT_NVM_DONE       4
`define BIT_SYNC1_COLL     3
`define BIT_CAPTURE2       0
`define BIT_CAPTURE4       5
`define BIT_CAPTURE3       4
`define BIT_TIMER6_MATCH   3
`define BIT_TIMER4_MATCH   1
`define BIT_SYNC2_COLL     1
`define BIT_SYNC_PORT2     0
`define BIT_GLOBAL_EN      7
`define BIT_PERIPH_EN      6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_FLAGS     8'h00
`define RST_ENABLE    8'h00
`define RST_CORE_CTRL 8'h00
`define RST_TMR0_OPT  8'h00

`endif

// >>> verilog/flag_reg8.v
// one 8-bit request flag register: hardware set, hardware clear, software write
// assumes event inputs are synchronous to core_clk
`timescale 1ns/10ps
`include "irq_flag_map.vh"

module flag_reg8 #(
	parameter [7:0] IMPL_MASK = 8'hff,
	parameter [7:0] SWWR_MASK = 8'hff
) (
	input  wire       core_clk,
	input  wire       srst,
	input  wire [7:0] hwSet,
	input  wire [7:0] hwClr,
	input  wire       swWr,
	input  wire [7:0] swData,
	output wire [7:0] flags
);

	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : gBit
			if (IMPL_MASK[i]) begin : gImpl
				reg bit_ff;
				always @(posedge core_clk) begin
					if (srst)
						bit_ff <= 1'b0;
					else if (hwSet[i])
						bit_ff <= 1'b1;
					else if (hwClr[i])
						bit_ff <= 1'b0;
					else if (swWr && SWWR_MASK[i])
						bit_ff <= swData[i];
				end
				assign flags[i] = bit_ff;
			end else begin : gHole
				// unimplemented bit: no storage, reads zero, writes vanish
				assign flags[i] = 1'b0;
			end
		end
	endgenerate

endmodule // flag_reg8

// >>> verilog/peripheral_irq_flag_bank.v
// peripheral interrupt request flag bank with enables and request output
// assumes all event inputs are synchronous to core_clk, one cycle per event
// assumes a classic wishbone master that drops stb for a cycle after every ack
// What this block does
// - request 1 bit 7 timer1 gate, bit 6 conversion done; 1 pending
// - request 1 bits 5 and 4 serial receive/transmit, read-only to software
// - request 1 bit 3 sync port 1, bit 2 capture unit 1, read/write
// - request 1 bit 1 timer2 period match, bit 0 timer1 overflow
// - flags set on their event whatever the enables say
// - request 2 bit 7 oscillator fail, bit 6 comparator 2, bit 5 comparator 1
// - request 2 bit 4 nonvolatile write done, bit 3 sync port 1 collision
// - request 2 bit 0 capture unit 2; bits 2 and 1 read zero
// - request 3 bit 5 capture unit 4, bit 4 capture unit 3
// - request 3 bit 3 timer6 match, bit 1 timer4 match; rest read zero
// - request 4 bit 1 sync port 2 collision, held until software clears
// - request 4 bit 0 sync port 2 done, software clears it
// - request 4 bits 7 to 2 read as zero
// - every implemented flag resets to zero on any reset
// - request 4 flags take hardware sets while software may write them
// - no request leaves unless the peripheral enable is set too
// - each enable bit sits at its flag's position, 1 allows it
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "irq_flag_map.vh"

module peripheral_irq_flag_bank (
	input  wire        core_clk,
	input  wire        srst,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire        wb_ack_o,
	input  wire        timer1GateEvt,
	input  wire        adcDoneEvt,
	input  wire        uartRxPending,
	input  wire        uartTxPending,
	input  wire        syncPort1Evt,
	input  wire        captureUnit1Evt,
	input  wire        timer2MatchEvt,
	input  wire        timer1OverflowEvt,
	input  wire        oscFailEvt,
	input  wire        comparator2Evt,
	input  wire        comparator1Evt,
	input  wire        nvmWriteDoneEvt,
	input  wire        syncPort1CollisionEvt,
	input  wire        captureUnit2Evt,
	input  wire        captureUnit4Evt,
	input  wire        captureUnit3Evt,
	input  wire        timer6MatchEvt,
	input  wire        timer4MatchEvt,
	input  wire        syncPort2CollisionEvt,
	input  wire        syncPort2Evt,
	output wire        periphIrqReq
);

	// ------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------
	// low two address bits are ignored: every register is one aligned word
	function regHit;
		input [7:0] adr;
		input [7:0] ofs;
		begin
			regHit = (adr[7:2] == ofs[7:2]);
		end
	endfunction

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	reg        ack_ff;
	reg [31:0] rdData_ff;
	reg        irqReq_ff;
	reg [7:0]  enable1_ff;
	reg [7:0]  enable2_ff;
	reg [7:0]  enable3_ff;
	reg [7:0]  enable4_ff;
	reg [7:0]  coreCtrl_ff;
	reg [7:0]  tmr0Opt_ff;
	reg [7:0]  nxt_rdByte;
	wire       busReq;
	wire       wrByte0;
	wire       wrFlags1;
	wire       wrFlags2;
	wire       wrFlags3;
	wire       wrFlags4;
	wire       wrEnable1;
	wire       wrEnable2;
	wire       wrEnable3;
	wire       wrEnable4;
	wire       wrCoreCtrl;
	wire       wrTmr0Opt;
	wire       rdReq;
	wire [7:0] set1;
	wire [7:0] set2;
	wire [7:0] set3;
	wire [7:0] set4;
	wire [7:0] clr1;
	wire [7:0] flags1;
	wire [7:0] flags2;
	wire [7:0] flags3;
	wire [7:0] flags4;
	wire       pend1;
	wire       pend2;
	wire       pend3;
	wire       pend4;
	wire       globalIrqEnable;
	wire       peripheralIrqEnable;
	wire       anyEnabledFlag;

	// ------------------------------------------------------------------
	// wishbone handshake
	// ------------------------------------------------------------------
	// a request is served once; ack drops in the cycle after it rose
	assign busReq  = wb_cyc_i && wb_stb_i && !ack_ff;
	// only byte lane 0 carries data, so without it a write is dropped
	assign wrByte0 = busReq && wb_we_i && wb_sel_i[0];
	// reads have no side effects, so polling a flag can never lose an event
	assign rdReq   = busReq && !wb_we_i;

	always @(posedge core_clk) begin
		if (srst)
			ack_ff <= 1'b0;
		else
			ack_ff <= busReq;
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdData_ff;

	// ------------------------------------------------------------------
	// hardware set and clear vectors
	// ------------------------------------------------------------------
	// flags take events with no look at the enables or global gates
	// events are taken as synchronous to core_clk; a source from another
	// domain must be synchronised before it reaches this bank
	assign set1[`BIT_TIMER1_GATE]  = timer1GateEvt;
	assign set1[`BIT_ADC_DONE]     = adcDoneEvt;
	// serial flags mirror the port's own pending level
	assign set1[`BIT_UART_RX]      = uartRxPending;
	assign set1[`BIT_UART_TX]      = uartTxPending;
	assign set1[`BIT_SYNC_PORT1]   = syncPort1Evt;
	assign set1[`BIT_CAPTURE1]     = captureUnit1Evt;
	assign set1[`BIT_TIMER2_MATCH] = timer2MatchEvt;
	assign set1[`BIT_TIMER1_OVF]   = timer1OverflowEvt;

	assign clr1 = {2'b00, ~uartRxPending, ~uartTxPending, 4'h0};

	assign set2 = {oscFailEvt,
		comparator2Evt,
		comparator1Evt,
		nvmWriteDoneEvt,
		syncPort1CollisionEvt,
		2'b00,
		captureUnit2Evt};

	assign set3 = {2'b00,
		captureUnit4Evt,
		captureUnit3Evt,
		timer6MatchEvt,
		1'b0,
		timer4MatchEvt,
		1'b0};

	assign set4 = {6'h00,
		syncPort2CollisionEvt,
		syncPort2Evt};

	// ------------------------------------------------------------------
	// register write strobes
	// ------------------------------------------------------------------
	// a strobe only fires on a taken write with byte lane 0 enabled
	assign wrFlags1   = wrByte0 && regHit(wb_adr_i, `OFS_FLAGS1);
	assign wrFlags2   = wrByte0 && regHit(wb_adr_i, `OFS_FLAGS2);
	assign wrFlags3   = wrByte0 && regHit(wb_adr_i, `OFS_FLAGS3);
	assign wrFlags4   = wrByte0 && regHit(wb_adr_i, `OFS_FLAGS4);
	assign wrEnable1  = wrByte0 && regHit(wb_adr_i, `OFS_ENABLE1);
	assign wrEnable2  = wrByte0 && regHit(wb_adr_i, `OFS_ENABLE2);
	assign wrEnable3  = wrByte0 && regHit(wb_adr_i, `OFS_ENABLE3);
	assign wrEnable4  = wrByte0 && regHit(wb_adr_i, `OFS_ENABLE4);
	assign wrCoreCtrl = wrByte0 && regHit(wb_adr_i, `OFS_CORE_CTRL);
	assign wrTmr0Opt  = wrByte0 && regHit(wb_adr_i, `OFS_TMR0_OPT);

	// ------------------------------------------------------------------
	// flag registers
	// ------------------------------------------------------------------
	// a write of 1 to a writable flag sets it, so software can exercise
	// the request path without the peripheral

	flag_reg8 #(
		.IMPL_MASK (`IMPL_MASK1),
		.SWWR_MASK (`SWWR_MASK1)
	) uFlags1 (
		.core_clk (core_clk),
		.srst     (srst),
		.hwSet    (set1),
		.hwClr    (clr1),
		.swWr     (wrFlags1),
		.swData   (wb_dat_i[7:0]),
		.flags    (flags1)
	);

	flag_reg8 #(
		.IMPL_MASK (`IMPL_MASK2),
		.SWWR_MASK (`SWWR_MASK2)
	) uFlags2 (
		.core_clk (core_clk),
		.srst     (srst),
		.hwSet    (set2),
		.hwClr    (8'h00),
		.swWr     (wrFlags2),
		.swData   (wb_dat_i[7:0]),
		.flags    (flags2)
	);

	flag_reg8 #(
		.IMPL_MASK (`IMPL_MASK3),
		.SWWR_MASK (`SWWR_MASK3)
	) uFlags3 (
		.core_clk (core_clk),
		.srst     (srst),
		.hwSet    (set3),
		.hwClr    (8'h00),
		.swWr     (wrFlags3),
		.swData   (wb_dat_i[7:0]),
		.flags    (flags3)
	);

	flag_reg8 #(
		.IMPL_MASK (`IMPL_MASK4),
		.SWWR_MASK (`SWWR_MASK4)
	) uFlags4 (
		.core_clk (core_clk),
		.srst     (srst),
		.hwSet    (set4),
		.hwClr    (8'h00),
		.swWr     (wrFlags4),
		.swData   (wb_dat_i[7:0]),
		.flags    (flags4)
	);

	// ------------------------------------------------------------------
	// enable and control registers
	// ------------------------------------------------------------------
	// enable bits share positions with their flags; holes stay zero
	// with core control bits 7 and 6 set, enabling a source whose flag already stands raises the request next edge
	always @(posedge core_clk) begin
		if (srst) begin
			enable1_ff <= `RST_ENABLE;
			enable2_ff <= `RST_ENABLE;
			enable3_ff <= `RST_ENABLE;
			enable4_ff <= `RST_ENABLE;
		end else begin
			if (wrEnable1)
				enable1_ff <= wb_dat_i[7:0] & `IMPL_MASK1;
			if (wrEnable2)
				enable2_ff <= wb_dat_i[7:0] & `IMPL_MASK2;
			if (wrEnable3)
				enable3_ff <= wb_dat_i[7:0] & `IMPL_MASK3;
			if (wrEnable4)
				enable4_ff <= wb_dat_i[7:0] & `IMPL_MASK4;
		end
	end

	// core control keeps its other bits as plain storage for the cpu side
	always @(posedge core_clk) begin
		if (srst) begin
			coreCtrl_ff <= `RST_CORE_CTRL;
			tmr0Opt_ff  <= `RST_TMR0_OPT;
		end else begin
			if (wrCoreCtrl)
				coreCtrl_ff <= wb_dat_i[7:0];
			if (wrTmr0Opt)
				tmr0Opt_ff <= wb_dat_i[7:0];
		end
	end

	assign globalIrqEnable     = coreCtrl_ff[`BIT_GLOBAL_EN];
	assign peripheralIrqEnable = coreCtrl_ff[`BIT_PERIPH_EN];

	// ------------------------------------------------------------------
	// interrupt request
	// ------------------------------------------------------------------
	// with both core enables set, a stale pending flag fires as soon as its enable is written, which is
	// why software clears the flag first
	// per-register terms keep the or-tree shallow ahead of the request flop
	assign pend1 = |(flags1 & enable1_ff);
	assign pend2 = |(flags2 & enable2_ff);
	assign pend3 = |(flags3 & enable3_ff);
	assign pend4 = |(flags4 & enable4_ff);
	assign anyEnabledFlag = pend1 | pend2 | pend3 | pend4;

	always @(posedge core_clk) begin
		if (srst)
			irqReq_ff <= 1'b0;
		else
			irqReq_ff <= anyEnabledFlag
				&& peripheralIrqEnable
				&& globalIrqEnable;
	end

	assign periphIrqReq = irqReq_ff;

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	// unmapped words answer with zero so the master never hangs
	always @* begin
		nxt_rdByte = 8'h00;
		if (regHit(wb_adr_i, `OFS_FLAGS1))
			nxt_rdByte = flags1;
		else if (regHit(wb_adr_i, `OFS_FLAGS2))
			nxt_rdByte = flags2;
		else if (regHit(wb_adr_i, `OFS_FLAGS3))
			nxt_rdByte = flags3;
		else if (regHit(wb_adr_i, `OFS_FLAGS4))
			nxt_rdByte = flags4;
		else if (regHit(wb_adr_i, `OFS_ENABLE1))
			nxt_rdByte = enable1_ff;
		else if (regHit(wb_adr_i, `OFS_ENABLE2))
			nxt_rdByte = enable2_ff;
		else if (regHit(wb_adr_i, `OFS_ENABLE3))
			nxt_rdByte = enable3_ff;
		else if (regHit(wb_adr_i, `OFS_ENABLE4))
			nxt_rdByte = enable4_ff;
		else if (regHit(wb_adr_i, `OFS_CORE_CTRL))
			nxt_rdByte = coreCtrl_ff;
		else if (regHit(wb_adr_i, `OFS_TMR0_OPT))
			nxt_rdByte = tmr0Opt_ff;
	end

	// data is captured with the ack edge; it shows flags before that
	// edge's own updates
	always @(posedge core_clk) begin
		if (srst)
			rdData_ff <= 32'h00000000;
		else if (rdReq)
			rdData_ff <= {24'h000000, nxt_rdByte};
		else
			rdData_ff <= 32'h00000000;
	end

endmodule // peripheral_irq_flag_bank

// >>> sim/irq_bank_props.sv
// concurrent checks on the peripheral flag bank ports
// assumes one core_clk domain and the synchronous srst of the design
`timescale 1ns/10ps
module irq_bank_props (
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        timer1OverflowEvt,
	input wire logic        syncPort2CollisionEvt,
	input wire logic        uartRxPending,
	input wire logic        periphIrqReq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// ----------------------------------------------------------------------
	// named steps of a register read
	// ----------------------------------------------------------------------
	sequence taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence rd(logic [7:0] a);
		taken and (!wb_we_i && wb_adr_i[7:2] == a[7:2]);
	endsequence
	// ----------------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------------
	chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	chk_ack_answers: assert property (taken |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	chk_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	chk_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	chk_flags2_holes: assert property (rd(8'h04) |=> wb_dat_o[2:1] == 2'h0)
		else $error("flags2 hole bits set");
	chk_flags3_holes: assert property (rd(8'h08) |=> (wb_dat_o[7:0] & 8'hc5) == 8'h0)
		else $error("flags3 hole bits set");
	chk_flags4_holes: assert property (rd(8'h0c) |=> wb_dat_o[31:2] == 30'h0)
		else $error("flags4 hole bits set");
	chk_ovf_sets_flag: assert property (timer1OverflowEvt ##1 !wb_cyc_i ##1 rd(8'h00) |=> wb_dat_o[0])
		else $error("overflow event not latched");
	chk_coll_sets_flag: assert property (syncPort2CollisionEvt ##1 !wb_cyc_i ##1 rd(8'h0c) |=> wb_dat_o[1])
		else $error("collision event not latched");
	chk_rx_follows: assert property (uartRxPending ##1 rd(8'h00) |=> wb_dat_o[5])
		else $error("receive flag does not follow level");
	chk_irq_after_reset: assert property ($past(srst) |-> !periphIrqReq)
		else $error("request high right after reset");
endmodule // irq_bank_props
bind peripheral_irq_flag_bank irq_bank_props u_props (.core_clk(core_clk), .srst(srst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer1OverflowEvt(timer1OverflowEvt),
	.syncPort2CollisionEvt(syncPort2CollisionEvt), .uartRxPending(uartRxPending),
	.periphIrqReq(periphIrqReq));

// >>> sim/periph_event_model.sv
// on-chip peripherals: turns a one-cycle request into an event pulse
// assumes the bench raises fireVec for one cycle per burst of events
`timescale 1ns/10ps
module periph_event_model (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic [17:0] fireVec,
	output reg        [17:0] evtPulse_ff
);
	// registered so events land one edge after the request, like a real source
	always @(posedge core_clk) begin
		evtPulse_ff <= srst ? 18'h0 : fireVec;
	end
endmodule // periph_event_model

// >>> sim/peripheral_irq_flag_bank_bench.sv
// self-checking bench for the peripheral flag bank over classic wishbone
// assumes the event model pulses one cycle after each fire request
`timescale 1ns/10ps
`include "irq_flag_map.vh"
module peripheral_irq_flag_bank_bench;
	reg         core_clk = 1'b0;
	reg         srst = 1'b1;
	reg         wbCyc = 1'b0;
	reg         wbStb = 1'b0;
	reg         wbWe = 1'b0;
	reg  [7:0]  wbAdr = 8'h00;
	reg  [3:0]  wbSel = 4'h0;
	reg  [31:0] wbDat = 32'h0;
	reg         uartRx = 1'b0;
	reg         uartTx = 1'b0;
	reg  [17:0] fireVec = 18'h0;
	wire [31:0] wbDatO;
	wire        wbAck;
	wire        irqReq;
	wire [17:0] evt;
	integer     miscompares = 0;
	integer     cmp_count = 0;
	integer     i;
	reg  [7:0]  a;
	reg  [31:0] q;
	int         evtBit [18] = '{7, 6, 3, 2, 1, 0, 7, 6, 5, 4, 3, 0, 5, 4, 3, 1, 1, 0};
	reg  [7:0]  swMask [4] = '{`SWWR_MASK1, `SWWR_MASK2, `SWWR_MASK3, `SWWR_MASK4};

	always #4 core_clk = ~core_clk;

	peripheral_irq_flag_bank dut (.core_clk(core_clk), .srst(srst), .wb_cyc_i(wbCyc),
		.wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
		.wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
		.timer1GateEvt(evt[17]), .adcDoneEvt(evt[16]), .uartRxPending(uartRx),
		.uartTxPending(uartTx), .syncPort1Evt(evt[15]), .captureUnit1Evt(evt[14]),
		.timer2MatchEvt(evt[13]), .timer1OverflowEvt(evt[12]), .oscFailEvt(evt[11]),
		.comparator2Evt(evt[10]), .comparator1Evt(evt[9]), .nvmWriteDoneEvt(evt[8]),
		.syncPort1CollisionEvt(evt[7]), .captureUnit2Evt(evt[6]),
		.captureUnit4Evt(evt[5]), .captureUnit3Evt(evt[4]), .timer6MatchEvt(evt[3]),
		.timer4MatchEvt(evt[2]), .syncPort2CollisionEvt(evt[1]), .syncPort2Evt(evt[0]),
		.periphIrqReq(irqReq));

	periph_event_model partner (.core_clk(core_clk), .srst(srst), .fireVec(fireVec),
		.evtPulse_ff(evt));

	// ----------------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------------
	task chk(input [31:0] g, input [31:0] e);
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("FAIL at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wb(input [7:0] ad, input w, input [7:0] d, input [3:0] s);
		integer n;
		begin
			n = 0;
			wbCyc <= 1'b1;
			wbStb <= 1'b1;
			wbWe <= w;
			wbAdr <= ad;
			wbSel <= s;
			wbDat <= {24'h0, d};
			@(posedge core_clk);
			while (wbAck !== 1'b1 && n < 40) begin
				@(posedge core_clk);
				n = n + 1;
			end
			q = wbDatO;
			if (n == 40)
				chk(32'h0, 32'h1);
			wbCyc <= 1'b0;
			wbStb <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	task wr(input [7:0] ad, input [7:0] d);
		wb(ad, 1'b1, d, 4'h1);
	endtask
	task rd(input [7:0] ad, input [7:0] e);
		wb(ad, 1'b0, 8'h00, 4'hf);
		chk(q, {24'h0, e});
	endtask
	task fire(input [17:0] v);
		fireVec <= v;
		@(posedge core_clk);
		fireVec <= 18'h0;
		repeat (2) @(posedge core_clk);
	endtask
	task tally_and_finish;
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------------
	initial begin
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		for (i = 0; i < 11; i = i + 1) rd(8'(i * 4), 8'h00);
		for (i = 0; i < 18; i = i + 1) begin
			a = (i < 6) ? 8'h00 : (i < 12) ? 8'h04 : (i < 16) ? 8'h08 : 8'h0c;
			fire(18'h20000 >> i);
			rd(a, 8'h01 << evtBit[i]);
			wr(a, 8'h00);
			rd(a, 8'h00);
		end
		fire(18'h3ffff);
		for (i = 0; i < 4; i = i + 1) begin
			rd(8'(i * 4), swMask[i]);
			wr(8'(i * 4), 8'h00);
			wr(8'(i * 4), 8'hff);
			rd(8'(i * 4), swMask[i]);
			wr(8'(i * 4), 8'h00);
		end
		uartRx <= 1'b1;
		uartTx <= 1'b1;
		repeat (2) @(posedge core_clk);
		wr(`OFS_FLAGS1, 8'h00);
		rd(`OFS_FLAGS1, 8'h30);
		uartRx <= 1'b0;
		uartTx <= 1'b0;
		repeat (2) @(posedge core_clk);
		rd(`OFS_FLAGS1, 8'h00);
		wr(`OFS_ENABLE2, 8'hff);
		rd(`OFS_ENABLE2, 8'hf9);
		wb(`OFS_ENABLE2, 1'b1, 8'h00, 4'he);
		rd(`OFS_ENABLE2, 8'hf9);
		wr(`OFS_ENABLE2, 8'h00);
		wr(`OFS_TMR0_OPT, 8'ha5);
		rd(`OFS_TMR0_OPT, 8'ha5);
		wr(8'h28, 8'hff);
		rd(8'h28, 8'h00);
		fire(18'h01000);
		wr(`OFS_ENABLE1, 8'h01);
		wr(`OFS_CORE_CTRL, 8'h80);
		chk({31'h0, irqReq}, 32'h0);
		wr(`OFS_CORE_CTRL, 8'h40);
		chk({31'h0, irqReq}, 32'h0);
		wr(`OFS_CORE_CTRL, 8'hc0);
		chk({31'h0, irqReq}, 32'h1);
		wr(`OFS_ENABLE1, 8'h02);
		chk({31'h0, irqReq}, 32'h0);
		wr(`OFS_ENABLE1, 8'h01);
		wr(`OFS_FLAGS1, 8'h00);
		chk({31'h0, irqReq}, 32'h0);
		fireVec <= 18'h01000;
		@(posedge core_clk);
		fireVec <= 18'h0;
		wr(`OFS_FLAGS1, 8'h00);
		rd(`OFS_FLAGS1, 8'h01);
		chk({31'h0, irqReq}, 32'h1);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		rd(`OFS_CORE_CTRL, 8'h00);
		rd(`OFS_FLAGS1, 8'h00);
		chk({31'h0, irqReq}, 32'h0);
		tally_and_finish;
	end

	// the bench's 108 transfers fit well inside this span
	initial begin
		#200000;
		miscompares = miscompares + 1;
		tally_and_finish;
	end
endmodule // peripheral_irq_flag_bank_bench
